// file: logic/ecc_pkg.sv
package ecc_pkg;

	// ***************************************************************
	// widths
	// ***************************************************************
	localparam int CNT_W = 16;
	localparam int FLAG_W = 5;
	localparam int INTE_W = 3;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

	// ***************************************************************
	// register indexes, byte address is four times the index
	// ***************************************************************
	localparam logic [7:0] IDX_CTL = 8'h00;
	localparam logic [7:0] IDX_IFR = 8'h02;
	localparam logic [7:0] IDX_ICLR = 8'h04;
	localparam logic [7:0] IDX_IFRC = 8'h06;
	localparam logic [7:0] IDX_CNT = 8'h08;
	localparam logic [7:0] IDX_MASK = 8'h0A;
	localparam logic [7:0] IDX_RISE0 = 8'h10;
	localparam logic [7:0] IDX_FALL0 = 8'h12;
	localparam logic [7:0] IDX_RISE1 = 8'h18;
	localparam logic [7:0] IDX_FALL1 = 8'h1A;

	// ***************************************************************
	// control register fields
	// ***************************************************************
	localparam int CTL_SOFT = 0;
	localparam int CTL_RISEINTE = 1;
	localparam int CTL_FALLINTE = 2;
	localparam int CTL_OVFINTE = 3;
	localparam int CTL_CLKSEL = 8;

	// ***************************************************************
	// flag, clear, force and mask fields
	// ***************************************************************
	localparam int FLG_INT = 0;
	localparam int FLG_RISE = 1;
	localparam int FLG_FALL = 2;
	localparam int FLG_OVF = 3;
	localparam int FLG_RISEOVF = 4;
	localparam logic [FLAG_W-1:0] FORCE_MASK = 5'h0E;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic [FLAG_W-1:0] FLAG_RST = 5'h00;
	localparam logic [FLAG_W-1:0] MASK_RST = 5'h00;
	localparam logic [INTE_W-1:0] INTE_RST = 3'h0;
	localparam logic CLKSEL_RST = 1'b0;

endpackage

// file: logic/ecc_cap_if.sv
`timescale 1ns/1ps
interface ecc_cap_if;
	import ecc_pkg::*;
	logic ce;
	logic clk_sel;
	logic soft_clr;
	logic sig_rise;
	logic sig_fall;
	logic pll_tick;
	logic ovf_evt;
	logic [CNT_W-1:0] counter;
	logic [CNT_W-1:0] rise0;
	logic [CNT_W-1:0] rise1;
	logic [CNT_W-1:0] fall0;
	logic [CNT_W-1:0] fall1;

	modport det (
		input ce,
		output sig_rise,
		output sig_fall,
		output pll_tick
	);
	modport core (
		input ce,
		input clk_sel,
		input soft_clr,
		input sig_rise,
		input sig_fall,
		input pll_tick,
		output ovf_evt,
		output counter,
		output rise0,
		output rise1,
		output fall0,
		output fall1
	);
	modport ctl (
		output ce,
		output clk_sel,
		output soft_clr,
		input sig_rise,
		input sig_fall,
		input ovf_evt,
		input counter,
		input rise0,
		input rise1,
		input fall0,
		input fall1
	);
endinterface

// file: logic/ecc_edge_det.sv
`timescale 1ns/1ps
module ecc_edge_det (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] sig_in,
	ecc_cap_if.det cap
);
	import ecc_pkg::*;

	typedef struct packed {
		logic [1:0] prev;
	} ecc_det_s;

	ecc_det_s state_ff;
	ecc_det_s nxt_state;
	logic [1:0] rise;
	logic [1:0] fall;

	// bit 0 is the timed input, bit 1 the secondary pll clock
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_edge
			assign rise[gi] = cap.ce & sig_in[gi] & ~state_ff.prev[gi];
			assign fall[gi] = cap.ce & ~sig_in[gi] & state_ff.prev[gi];
		end
	endgenerate

	assign cap.sig_rise = rise[0];
	assign cap.sig_fall = fall[0];
	assign cap.pll_tick = rise[1];

	always_comb begin
		nxt_state = state_ff;
		if (cap.ce) begin
			nxt_state.prev = sig_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
endmodule // ecc_edge_det

// file: logic/ecc_capture_core.sv
`timescale 1ns/1ps
module ecc_capture_core (
	input wire logic pclk,
	input wire logic presetn,
	ecc_cap_if.core cap
);
	import ecc_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] rise0;
		logic [CNT_W-1:0] rise1;
		logic [CNT_W-1:0] fall0;
		logic [CNT_W-1:0] fall1;
	} ecc_core_s;

	ecc_core_s state_ff;
	ecc_core_s nxt_state;
	logic tick;
	logic edge_evt;

	assign tick = cap.clk_sel ? cap.pll_tick : 1'b1;
	assign edge_evt = cap.sig_rise | cap.sig_fall;
	// an edge on the wrap cycle clears instead, so no overflow then
	assign cap.ovf_evt = cap.ce & tick & ~edge_evt & ~cap.soft_clr & (state_ff.cnt == CNT_MAX);

	assign cap.counter = state_ff.cnt;
	assign cap.rise0 = state_ff.rise0;
	assign cap.rise1 = state_ff.rise1;
	assign cap.fall0 = state_ff.fall0;
	assign cap.fall1 = state_ff.fall1;

	always_comb begin
		nxt_state = state_ff;
		if (!cap.ce) begin
			nxt_state = state_ff;
		end else if (cap.soft_clr) begin
			nxt_state = '0;
		end else if (cap.sig_rise) begin
			nxt_state.rise1 = state_ff.rise0;
			nxt_state.rise0 = state_ff.cnt;
			nxt_state.cnt = CNT_RST;
		end else if (cap.sig_fall) begin
			nxt_state.fall1 = state_ff.fall0;
			nxt_state.fall0 = state_ff.cnt;
			nxt_state.cnt = CNT_RST;
		end else if (tick) begin
			nxt_state.cnt = state_ff.cnt + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
endmodule // ecc_capture_core

// file: logic/ecc_top.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ecc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic module_clock_enable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_in,
	input wire logic secondary_pll_clock,
	output logic irq
);
	import ecc_pkg::*;

	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		logic clk_sel;
		logic [INTE_W-1:0] inte;
		logic [FLAG_W-1:0] flags;
		logic [FLAG_W-1:0] mask;
		logic [31:0] rdata;
		logic err;
	} ecc_top_s;

	ecc_top_s state_ff;
	ecc_top_s nxt_state;

	ecc_cap_if cap ();

	// ***************************************************************
	// sub-blocks
	// ***************************************************************
	ecc_edge_det u_det (
		.pclk(pclk),
		.presetn(presetn),
		.sig_in({secondary_pll_clock, capture_in}),
		.cap(cap)
	);

	ecc_capture_core u_core (
		.pclk(pclk),
		.presetn(presetn),
		.cap(cap)
	);

	// ***************************************************************
	// bus decode
	// ***************************************************************
	logic setup_ph;
	logic wr_acc;
	logic [7:0] widx;
	logic aligned;
	logic low_lane;
	logic wr_ctl;
	logic wr_ifr;
	logic wr_iclr;
	logic wr_ifrc;
	logic wr_mask;
	logic [31:0] rd_val;
	logic rd_hit;

	assign widx = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
	assign setup_ph = psel & ~penable;
	// slave always answers in the first access cycle
	assign pready = 1'b1;
	assign prdata = state_ff.rdata;
	assign pslverr = psel & penable & state_ff.err;
	assign low_lane = pstrb[0];
	// writes only land while the module clock runs; reads stay live so software
	// can sample the frozen counter with the clock off
	assign wr_acc = psel & penable & pwrite & ~state_ff.err & module_clock_enable & low_lane;
	assign wr_ctl = wr_acc & (widx == IDX_CTL);
	assign wr_ifr = wr_acc & (widx == IDX_IFR);
	assign wr_iclr = wr_acc & (widx == IDX_ICLR);
	assign wr_ifrc = wr_acc & (widx == IDX_IFRC);
	assign wr_mask = wr_acc & (widx == IDX_MASK);

	assign cap.ce = module_clock_enable;
	assign cap.clk_sel = state_ff.clk_sel;
	assign cap.soft_clr = wr_ctl & pwdata[CTL_SOFT];

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (widx)
			IDX_CTL: begin
				// soft clear bit is a strobe and reads zero
				rd_val[CTL_CLKSEL] = state_ff.clk_sel;
				rd_val[CTL_OVFINTE:CTL_RISEINTE] = state_ff.inte;
			end
			IDX_IFR: begin
				rd_val[FLAG_W-1:0] = state_ff.flags;
			end
			IDX_ICLR: begin
				rd_val = 32'h0000_0000;
			end
			IDX_IFRC: begin
				rd_val = 32'h0000_0000;
			end
			IDX_CNT: begin
				rd_val[CNT_W-1:0] = cap.counter;
			end
			IDX_MASK: begin
				rd_val[FLAG_W-1:0] = state_ff.mask;
			end
			IDX_RISE0: begin
				rd_val[CNT_W-1:0] = cap.rise0;
			end
			IDX_FALL0: begin
				rd_val[CNT_W-1:0] = cap.fall0;
			end
			IDX_RISE1: begin
				rd_val[CNT_W-1:0] = cap.rise1;
			end
			IDX_FALL1: begin
				rd_val[CNT_W-1:0] = cap.fall1;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ***************************************************************
	// flags
	// ***************************************************************
	logic [FLAG_W-1:0] hw_set;
	logic [FLAG_W-1:0] sw_set;
	logic [FLAG_W-1:0] sw_clr;
	logic [FLAG_W-1:0] src_set;
	logic enabled_evt;

	always_comb begin
		hw_set = '0;
		hw_set[FLG_RISE] = cap.sig_rise;
		hw_set[FLG_FALL] = cap.sig_fall;
		hw_set[FLG_OVF] = cap.ovf_evt;
		hw_set[FLG_RISEOVF] = cap.sig_rise & state_ff.flags[FLG_RISE];
	end

	assign sw_set = wr_ifrc ? (pwdata[FLAG_W-1:0] & FORCE_MASK) : '0;
	assign sw_clr = (wr_iclr | wr_ifr) ? pwdata[FLAG_W-1:0] : '0;
	assign src_set = hw_set | sw_set;
	assign enabled_evt = (src_set[FLG_RISE] & state_ff.inte[0])
		| (src_set[FLG_FALL] & state_ff.inte[1])
		| (src_set[FLG_OVF] & state_ff.inte[2]);

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		nxt_state = state_ff;
		if (setup_ph) begin
			nxt_state.err = ~aligned | ~rd_hit;
			nxt_state.rdata = (aligned & rd_hit) ? rd_val : 32'h0000_0000;
		end
		if (module_clock_enable) begin
			if (wr_ctl) begin
				nxt_state.clk_sel = pwdata[CTL_CLKSEL];
				nxt_state.inte = pwdata[CTL_OVFINTE:CTL_RISEINTE];
			end
			if (wr_mask) begin
				nxt_state.mask = pwdata[FLAG_W-1:0];
			end
			// set wins over a clear in the same cycle
			nxt_state.flags = (state_ff.flags & ~sw_clr) | src_set;
			// the global flag latches until software clears it; events while it is set cannot retrigger it
			if (enabled_evt) begin
				nxt_state.flags[FLG_INT] = 1'b1;
			end
			// soft clear beats every set, hardware or forced
			if (cap.soft_clr) begin
				nxt_state.flags = FLAG_RST;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff.clk_sel <= CLKSEL_RST;
			state_ff.inte <= INTE_RST;
			state_ff.flags <= FLAG_RST;
			state_ff.mask <= MASK_RST;
			state_ff.rdata <= 32'h0000_0000;
			state_ff.err <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ***************************************************************
	// interrupt
	// ***************************************************************
	// level output; with only the global bit unmasked the line rises once per
	// service, since the global flag stays set until software clears it
	assign irq = |(state_ff.flags & state_ff.mask);

endmodule // ecc_top

// file: test/ecc_assertions.sv
`timescale 1ns/1ps
module ecc_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic module_clock_enable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic capture_in,
	input wire logic secondary_pll_clock,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic rd = acc && !pwrite;
	wire logic wr = acc && pwrite && pstrb[0] && module_clock_enable;
	wire logic cnt_rd = rd && paddr == 12'h020;
	// ********
	// bus answers
	// ********
	pready_high_a: assert property (pready) else $error("pready low");
	err_unaligned_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	ctl_soft_zero_a: assert property (rd && paddr == 12'h000 |-> !prdata[0])
		else $error("soft clear bit reads one");
	// a capture in the gap would legally refill a register, hence the stable input
	soft_clear_a: assert property (wr && paddr == 12'h000 && pwdata[0]
		##1 $stable(capture_in)
		##1 psel && !penable && !pwrite && paddr inside {12'h008, 12'h040, 12'h048, 12'h060,
		12'h068} |=> prdata == 32'h0) else $error("soft clear left state");
	// ********
	// interrupt and frozen counter
	// ********
	irq_fall_a: assert property ($fell(irq) |-> $past(wr))
		else $error("irq fell without a write");
	irq_rise_a: assert property ($rose(irq) |-> $past(module_clock_enable))
		else $error("irq rose while frozen");
	frozen_cnt_a: assert property (cnt_rd && !module_clock_enable
		&& !$past(module_clock_enable) ##3 cnt_rd && !$past(module_clock_enable, 2)
		|-> prdata == $past(prdata, 3)) else $error("counter moved while frozen");
	cover property (rd && paddr == 12'h040 && prdata != 32'h0);
	cover property ($rose(irq));
	cover property (acc && pslverr);
endmodule // ecc_checker

bind ecc_top ecc_checker ecc_checker_i (.pclk(pclk), .presetn(presetn),
	.module_clock_enable(module_clock_enable), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .capture_in(capture_in),
	.secondary_pll_clock(secondary_pll_clock), .irq(irq));

// file: test/ecc_pulse_src.sv
`timescale 1ns/1ps
module ecc_pulse_src (
	input wire logic pclk,
	output logic capture_in,
	output logic secondary_pll_clock
);
	logic [1:0] div_ff = 2'h0;
	initial capture_in = 1'b0;
	initial secondary_pll_clock = 1'b0;
	// synchronous stand-in for the pll: one rise every four system cycles
	always @(posedge pclk) begin
		div_ff <= div_ff + 2'h1;
		secondary_pll_clock <= div_ff[1];
	end
	task automatic drive(input int n, input logic lvl);
		repeat (n) @(posedge pclk);
		capture_in <= lvl;
	endtask
endmodule // ecc_pulse_src

// file: test/ecc_tb_top.sv
`timescale 1ns/1ps
module ecc_tb_top;
	import ecc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic module_clock_enable = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic capture_in;
	logic secondary_pll_clock;
	logic irq;
	logic [31:0] rdat;
	logic rerr;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	always #5 pclk = ~pclk;
	ecc_top ecc_top_i (.pclk(pclk), .presetn(presetn), .module_clock_enable(module_clock_enable),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_in(capture_in), .secondary_pll_clock(secondary_pll_clock), .irq(irq));
	ecc_pulse_src ecc_pulse_src_i (.pclk(pclk), .capture_in(capture_in),
		.secondary_pll_clock(secondary_pll_clock));
	// ********
	// bus and compare helpers
	// ********
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, {2'b00, i, 2'b00}, d);
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
		chk(rdat, e);
	endtask
	task automatic irq_is(input logic e);
		@(negedge pclk);
		chk({31'h0, irq}, {31'h0, e});
		// back on the rising edge so the caller drives inputs there
		@(posedge pclk);
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_reset();
		logic [7:0] r [8] = '{IDX_CTL, IDX_IFR, IDX_CNT, IDX_MASK, IDX_RISE0, IDX_FALL0,
			IDX_RISE1, IDX_FALL1};
		foreach (r[i]) rd(r[i], 32'h0);
	endtask
	task automatic t_count();
		module_clock_enable <= 1'b1;
		wr(IDX_CTL, 32'h1);
		repeat (20) @(posedge pclk);
		module_clock_enable <= 1'b0;
		rd(IDX_CNT, 32'h14);
		rd(IDX_CNT, 32'h14);
	endtask
	task automatic t_capture();
		module_clock_enable <= 1'b1;
		wr(IDX_CTL, 32'h1);
		ecc_pulse_src_i.drive(5, 1'b1);
		ecc_pulse_src_i.drive(7, 1'b0);
		ecc_pulse_src_i.drive(9, 1'b1);
		repeat (4) @(posedge pclk);
		module_clock_enable <= 1'b0;
		rd(IDX_RISE0, 32'h8);
		rd(IDX_RISE1, 32'h5);
		rd(IDX_FALL0, 32'h6);
		rd(IDX_FALL1, 32'h0);
		rd(IDX_CNT, 32'h3);
		rd(IDX_IFR, 32'h16);
		module_clock_enable <= 1'b1;
		wr(IDX_RISE0, 32'hFFFF);
		rd(IDX_RISE0, 32'h8);
		wr(IDX_CTL, 32'h101);
		rd(IDX_IFR, 32'h0);
		repeat (37) @(posedge pclk);
		module_clock_enable <= 1'b0;
		// 40 enabled cycles after the clear hold exactly ten pll rises
		rd(IDX_CNT, 32'hA);
		rd(IDX_RISE0, 32'h0);
		rd(IDX_CTL, 32'h100);
	endtask
	task automatic t_overflow();
		module_clock_enable <= 1'b1;
		wr(IDX_MASK, 32'h1);
		wr(IDX_CTL, 32'h9);
		repeat (65540) @(posedge pclk);
		module_clock_enable <= 1'b0;
		rd(IDX_CNT, 32'h4);
		rd(IDX_IFR, 32'h9);
		irq_is(1'b1);
		module_clock_enable <= 1'b1;
		wr(IDX_MASK, 32'h0);
		irq_is(1'b0);
		wr(IDX_MASK, 32'h1);
		irq_is(1'b1);
		wr(IDX_ICLR, 32'h9);
		irq_is(1'b0);
		rd(IDX_IFR, 32'h0);
	endtask
	task automatic t_force();
		module_clock_enable <= 1'b1;
		wr(IDX_CTL, 32'h3);
		wr(IDX_MASK, 32'h2);
		wr(IDX_IFRC, 32'h4);
		rd(IDX_IFR, 32'h4);
		wr(IDX_IFRC, 32'h2);
		rd(IDX_IFR, 32'h7);
		irq_is(1'b1);
		wr(IDX_IFR, 32'h2);
		rd(IDX_IFR, 32'h5);
		irq_is(1'b0);
	endtask
	task automatic t_midreset();
		module_clock_enable <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(IDX_CNT, 32'h0);
		rd(IDX_CTL, 32'h0);
	endtask
	task automatic t_errors();
		apb(1'b0, 12'h002, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b0, 12'h0FC, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rdat, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_count();
		t_capture();
		t_overflow();
		t_force();
		t_midreset();
		t_errors();
		give_verdict();
	end
	// the overflow wait alone takes 65540 cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 70000) begin
			miscompares++;
			give_verdict();
		end
	end
endmodule // ecc_tb_top
